// ==== acn_pkg.sv ====
// Purpose: shared constants for the configuration word exchange block
// Assumes: 40 MHz system clock, word-wide register bus
// Notes:   field bit positions are those of the 16-bit configuration word; control and status register bits excepted
package acn_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned LINK_TIMER_NS  = 10000000;
  localparam int unsigned LINK_TIMER_CYC = (LINK_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef logic [19:0] acn_tmr_t;
  // configuration word fields
  localparam int unsigned FD_BIT     = 5;
  localparam int unsigned HD_BIT     = 6;
  localparam int unsigned PS_SYM_BIT = 7;
  localparam int unsigned PS_DIR_BIT = 8;
  localparam int unsigned RF_LO_BIT  = 12;
  localparam int unsigned ACK_BIT    = 14;
  localparam int unsigned NP_BIT     = 15;
  localparam logic [15:0] ACK_M      = 16'h4000;
  localparam logic [15:0] ADV_MASK   = 16'h81e0;
  localparam logic [15:0] ABIL_DEF   = 16'h81e0;
  // fault codes
  localparam logic [1:0]  RF_OK       = 2'h0;
  localparam logic [1:0]  RF_OFFLINE  = 2'h1;
  localparam logic [1:0]  RF_LINKFAIL = 2'h2;
  localparam logic [1:0]  RF_ANERR    = 2'h3;
  // transmit selector codes
  localparam logic [1:0]  XMIT_CFG  = 2'h0;
  localparam logic [1:0]  XMIT_IDLE = 2'h1;
  localparam logic [1:0]  XMIT_DATA = 2'h2;
  // receive matching
  localparam logic [1:0]  MATCH_CNT = 2'h3;
  // register map, byte offsets
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_ADV   = 8'h04;
  localparam logic [7:0]  REG_NPTX  = 8'h08;
  localparam logic [7:0]  REG_STAT  = 8'h0c;
  localparam logic [7:0]  REG_LPW   = 8'h10;
  localparam logic [7:0]  REG_FAULT = 8'h14;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RST_BIT   = 1;
  localparam int unsigned CTRL_SENSE_BIT = 2;
  localparam int unsigned STAT_RFLT_BIT  = 1;
  localparam logic [2:0]  CTRL_RST = 3'h5;
  localparam logic [15:0] ADV_RST  = 16'h01a0;
  // negotiation states
  typedef enum logic [3:0] {
    ST_NEG_ENABLE, ST_DISABLED, ST_RESTART, ST_ABILITY, ST_ACK,
    ST_COMPLETE_ACK, ST_NP_WAIT, ST_IDLE_DETECT, ST_LINK_OK
  } acn_st_t;
endpackage : acn_pkg

// ==== acn_match_if.sv ====
// Purpose: carries receive events to the matcher and match results back
// Assumes: one system clock
// Notes:   results are registered levels
`timescale 1ns/1ps
interface acn_match_if;
  logic        rx_valid;
  logic [15:0] rx_word;
  logic        rx_idle;
  logic        rx_invalid;
  logic        flush;
  logic        ability_match;
  logic        ack_match;
  logic        consist_match;
  logic        idle_match;
  logic [15:0] match_word;
  modport arb (output rx_valid, rx_word, rx_idle, rx_invalid, flush,
               input  ability_match, ack_match, consist_match, idle_match, match_word);
  modport mat (input  rx_valid, rx_word, rx_idle, rx_invalid, flush,
               output ability_match, ack_match, consist_match, idle_match, match_word);
endinterface : acn_match_if

// ==== acn_rx_match.sv ====
// Purpose: repeat, confirm, consistency and idle matching of received sets
// Assumes: rx_valid and rx_idle are one-cycle pulses, never together
// Notes:   flush or a received error drops all history
`timescale 1ns/1ps
module acn_rx_match (
  // clock and reset
  input wire logic   clk_sys_i,
  input wire logic   sys_rst_i,
  // arbitration side
  acn_match_if.mat   m
);
  typedef struct packed {
    logic [15:0] last;
    logic [1:0]  cnt;
    logic [1:0]  fcnt;
    logic [1:0]  icnt;
    logic        abil;
    logic        ackm;
    logic        cons;
    logic        idle;
    logic [15:0] word;
  } acn_mst_t;

  acn_mst_t r;
  acn_mst_t n;

  function automatic logic [15:0] noack(input logic [15:0] w);
    return w & ~acn_pkg::ACK_M;
  endfunction : noack

  function automatic logic [1:0] sat(input logic [1:0] c);
    return (c == acn_pkg::MATCH_CNT) ? c : c + 2'h1;
  endfunction : sat

  always_comb begin
    n = r;
    if (m.flush || m.rx_invalid) begin
      n = '0;
    end else if (m.rx_valid) begin
      n.last = m.rx_word;
      n.icnt = 2'h0;
      n.idle = 1'b0;
      n.cnt  = (noack(m.rx_word) == noack(r.last)) ? sat(r.cnt) : 2'h1;
      n.fcnt = (m.rx_word == r.last) ? sat(r.fcnt) : 2'h1;
      n.abil = (n.cnt == acn_pkg::MATCH_CNT);
      if (n.abil && !r.abil) begin
        n.word = m.rx_word;
      end
      n.ackm = (n.fcnt == acn_pkg::MATCH_CNT) && m.rx_word[acn_pkg::ACK_BIT];
      n.cons = noack(m.rx_word) == noack(n.word);
    end else if (m.rx_idle) begin
      n.icnt = sat(r.icnt);
      n.idle = (n.icnt == acn_pkg::MATCH_CNT);
      n.cnt  = 2'h0;
      n.fcnt = 2'h0;
      n.abil = 1'b0;
      n.ackm = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign m.ability_match = r.abil;
  assign m.ack_match     = r.ackm;
  assign m.consist_match = r.cons;
  assign m.idle_match    = r.idle;
  assign m.match_word    = r.word;

  a_abil_needs_three: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(r.abil) |-> $past(m.rx_valid) && r.cnt == acn_pkg::MATCH_CNT)
    else $error("repeat match raised without three equal words");
endmodule : acn_rx_match

// ==== acn_top.sv ====
// Purpose: base/next page configuration word exchange with register access
// Assumes: PCS delivers decoded words and set indications synchronous to clk
// Notes:   registers sit on an AHB-Lite slave with zero wait states
// Notes on behaviour
// - full duplex ability in bit 5, half duplex ability in bit 6
// - symmetric pause in bit 7, asymmetric direction in bit 8
// - pause pair decodes none, toward partner, symmetric, both toward local
// - fault code in bits 12 and 13, default zero
// - fault codes: ok, going offline, link failure, negotiation error
// - with fault sensing off the sent fault code is always zero; a code already sent stays a cycle, or through a complete-confirm hold
// - a sent fault code holds until idle watch after base page, then clears
// - received nonzero base page fault code sets the fault status bit
// - no fault code sent while sync fails; a code already sent stays a cycle, or through a complete-confirm hold; stored code sent once ok
// - all-zero received words beyond the link timer mean link failure
// - unresolvable abilities advertise the negotiation error code
// - receipt confirm flag sits in bit 14 of every page
// - confirm only after three equal words; next page holds until staged
// - in complete-confirm the word is frozen for the whole link timer
// - more-pages flag one asks or continues, zero ends pages
// - after restart send zero words, then the base page
// - advertise only abilities present, clearing some is allowed
// - sent word from advertisement value, or next page value in paging
// - selector picks config sets, idle sets, or idles with data
// - receive reports words, idles, and errors while sending config
// - receive logic makes repeat, confirm, consistency and idle matches
// - after exchange resolve highest common mode and enable it
// - reserved word bits are always sent as zero
// - any restart request returns to the enable state
// - full duplex wins over half duplex
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module acn_top #(
  parameter int unsigned LINK_TIMER_CYC = acn_pkg::LINK_TIMER_CYC,
  parameter logic [15:0] LOCAL_ABIL     = acn_pkg::ABIL_DEF
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // register bus
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // receive path
  input  wire logic        rx_cfg_valid_i,
  input  wire logic [15:0] rx_cfg_word_i,
  input  wire logic        rx_idle_i,
  input  wire logic        rx_invalid_i,
  input  wire logic        sync_ok_i,
  // transmit path
  output logic      [1:0]  xmit_o,
  output logic      [15:0] tx_cfg_word_o,
  // resolution
  output logic             an_done_o,
  output logic             res_full_duplex_o,
  output logic             res_pause_tx_o,
  output logic             res_pause_rx_o
);
  // one shared timer value for every hold and timeout
  localparam acn_pkg::acn_tmr_t LT = acn_pkg::acn_tmr_t'(LINK_TIMER_CYC);

  typedef struct packed {
    acn_pkg::acn_st_t  st;
    logic              np_mode;
    acn_pkg::acn_tmr_t tmr;
    acn_pkg::acn_tmr_t zcnt;
    logic              zero_seen;
    logic [2:0]        ctrl;
    logic [15:0]       adv;
    logic [15:0]       nptx;
    logic              np_staged;
    logic [1:0]        fault;
    logic              rflt;
    logic [15:0]       lpw;
    logic [15:0]       tx_word;
    logic [1:0]        xmit;
    logic              done;
    logic              fd;
    logic              ptx;
    logic              prx;
    logic              a_sel;
    logic              a_wr;
    logic [7:0]        a_addr;
    logic [31:0]       rdata;
  } acn_top_s_t;

  acn_top_s_t r;
  acn_top_s_t n;

  acn_match_if mi ();

  logic [15:0] adv_eff;
  logic [1:0]  fault_g;
  logic [15:0] page_r;
  logic [15:0] page_n;
  logic        restart_req;
  logic        rflt_set;
  logic        rflt_clr;
  logic        zero_to;
  logic        tmr_done;
  logic        dup_ok;
  logic        flush_c;
  logic [1:0]  pres;

  // outgoing page: reserved bits masked, fault code only in the base page
  function automatic logic [15:0] mk_page(input logic np, input logic [15:0] nptx,
                                          input logic [15:0] adv, input logic [1:0] flt);
    logic [15:0] w;
    w = np ? (nptx & ~acn_pkg::ACK_M) : (adv | {2'h0, flt, 12'h000});
    return w;
  endfunction : mk_page

  // pause pairing: {local transmit enable, local receive enable}
  function automatic logic [1:0] pause_res(input logic ls, input logic ld,
                                           input logic ps, input logic pd);
    logic [1:0] v;
    v = 2'b00;
    if (ls && ps) begin
      v = 2'b11;
    end else if (!ls && ld && ps && pd) begin
      v = 2'b10;
    end else if (ls && ld && !ps && pd) begin
      v = 2'b01;
    end
    return v;
  endfunction : pause_res

  assign mi.rx_valid   = rx_cfg_valid_i;
  assign mi.rx_word    = rx_cfg_word_i;
  assign mi.rx_idle    = rx_idle_i;
  assign mi.rx_invalid = rx_invalid_i && (r.xmit == acn_pkg::XMIT_CFG);
  assign mi.flush      = flush_c;

  acn_rx_match u_match (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .m         (mi)
  );

  always_comb begin
    n           = r;
    restart_req = 1'b0;
    rflt_clr    = 1'b0;
    // never advertise an ability that the device lacks
    adv_eff  = r.adv & LOCAL_ABIL & acn_pkg::ADV_MASK;
    fault_g  = sync_ok_i ? r.fault : acn_pkg::RF_OK;
    page_r   = mk_page(r.np_mode, r.nptx, adv_eff, fault_g);
    dup_ok   = (adv_eff[acn_pkg::FD_BIT] && r.lpw[acn_pkg::FD_BIT]) ||
               (adv_eff[acn_pkg::HD_BIT] && r.lpw[acn_pkg::HD_BIT]);
    pres     = pause_res(adv_eff[acn_pkg::PS_SYM_BIT], adv_eff[acn_pkg::PS_DIR_BIT],
                         r.lpw[acn_pkg::PS_SYM_BIT], r.lpw[acn_pkg::PS_DIR_BIT]);
    tmr_done = (r.tmr == LT);
    zero_to  = (r.zcnt == LT);

    // bus address phase; read data is ready for the data phase
    n.a_sel  = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
    n.a_wr   = hwrite_i;
    n.a_addr = haddr_i[7:0];
    if (n.a_sel && !hwrite_i) begin
      case (haddr_i[7:0])
        acn_pkg::REG_CTRL:  n.rdata = {29'h0, r.ctrl};
        acn_pkg::REG_ADV:   n.rdata = {16'h0, r.adv};
        acn_pkg::REG_NPTX:  n.rdata = {16'h0, r.nptx};
        acn_pkg::REG_STAT:  n.rdata = {24'h0, r.np_staged, r.st == acn_pkg::ST_NP_WAIT,
                                       r.prx, r.ptx, r.fd, sync_ok_i, r.rflt, r.done};
        acn_pkg::REG_LPW:   n.rdata = {16'h0, r.lpw};
        acn_pkg::REG_FAULT: n.rdata = {30'h0, r.fault};
        default:            n.rdata = 32'h0;
      endcase
    end
    // bus data phase writes
    if (r.a_sel && r.a_wr) begin
      case (r.a_addr)
        acn_pkg::REG_CTRL: begin
          n.ctrl      = hwdata_i[2:0] & ~(3'h1 << acn_pkg::CTRL_RST_BIT);
          restart_req = hwdata_i[acn_pkg::CTRL_RST_BIT];
        end
        acn_pkg::REG_ADV:   n.adv  = hwdata_i[15:0];
        acn_pkg::REG_NPTX: begin
          n.nptx      = hwdata_i[15:0];
          n.np_staged = 1'b1;
        end
        acn_pkg::REG_STAT:  rflt_clr = hwdata_i[acn_pkg::STAT_RFLT_BIT];
        acn_pkg::REG_FAULT: n.fault  = hwdata_i[1:0];
        default: ;
      endcase
    end

    // partner fault status, set wins over a same-cycle clear
    rflt_set = (r.st == acn_pkg::ST_ABILITY) && !r.np_mode && mi.ability_match &&
               (mi.match_word[13:12] != acn_pkg::RF_OK) && sync_ok_i;
    if (rflt_clr) begin
      n.rflt = 1'b0;
    end
    if (rflt_set) begin
      n.rflt = 1'b1;
    end

    // run of all-zero received words while looking for the partner page
    if (rx_cfg_valid_i) begin
      n.zero_seen = (rx_cfg_word_i == 16'h0000);
    end else if (rx_idle_i) begin
      n.zero_seen = 1'b0;
    end
    if (n.zero_seen && r.st == acn_pkg::ST_ABILITY) begin
      n.zcnt = zero_to ? r.zcnt : r.zcnt + 20'h1;
    end else begin
      n.zcnt = '0;
    end

    n.tmr = tmr_done ? r.tmr : r.tmr + 20'h1;

    unique case (r.st)
      acn_pkg::ST_NEG_ENABLE: begin
        n.np_mode = 1'b0;
        n.st = r.ctrl[acn_pkg::CTRL_EN_BIT] ? acn_pkg::ST_RESTART : acn_pkg::ST_DISABLED;
      end
      acn_pkg::ST_DISABLED: begin
        if (r.ctrl[acn_pkg::CTRL_EN_BIT]) begin
          n.st = acn_pkg::ST_NEG_ENABLE;
        end
      end
      acn_pkg::ST_RESTART: begin
        if (tmr_done) begin
          n.st = acn_pkg::ST_ABILITY;
        end
      end
      acn_pkg::ST_ABILITY: begin
        if (mi.ability_match && (mi.match_word & ~acn_pkg::ACK_M) != 16'h0000) begin
          n.st = acn_pkg::ST_ACK;
          if (!r.np_mode) begin
            n.lpw = mi.match_word;
          end
        end else if (zero_to && r.ctrl[acn_pkg::CTRL_SENSE_BIT]) begin
          n.fault = acn_pkg::RF_LINKFAIL;
          n.st    = acn_pkg::ST_NEG_ENABLE;
        end
      end
      acn_pkg::ST_ACK: begin
        if (mi.ack_match) begin
          n.st = mi.consist_match ? acn_pkg::ST_COMPLETE_ACK : acn_pkg::ST_NEG_ENABLE;
        end
      end
      acn_pkg::ST_COMPLETE_ACK: begin
        if (tmr_done) begin
          if (page_r[acn_pkg::NP_BIT] && mi.match_word[acn_pkg::NP_BIT]) begin
            n.st = acn_pkg::ST_NP_WAIT;
          end else if (!dup_ok && r.ctrl[acn_pkg::CTRL_SENSE_BIT]) begin
            n.fault = acn_pkg::RF_ANERR;
            n.st    = acn_pkg::ST_NEG_ENABLE;
          end else begin
            n.st  = acn_pkg::ST_IDLE_DETECT;
            n.fd  = adv_eff[acn_pkg::FD_BIT] && r.lpw[acn_pkg::FD_BIT];
            n.ptx = pres[1];
            n.prx = pres[0];
            if (!r.np_mode) begin
              n.fault = acn_pkg::RF_OK;
            end
          end
        end
      end
      acn_pkg::ST_NP_WAIT: begin
        // confirm stays up on the old page until software stages a new one
        if (r.np_staged) begin
          n.np_staged = 1'b0;
          n.np_mode   = 1'b1;
          n.st        = acn_pkg::ST_ABILITY;
        end
      end
      acn_pkg::ST_IDLE_DETECT: begin
        if (tmr_done && mi.idle_match) begin
          n.st = acn_pkg::ST_LINK_OK;
        end
      end
      acn_pkg::ST_LINK_OK: begin
        if (rx_cfg_valid_i) begin
          n.st = acn_pkg::ST_NEG_ENABLE;
        end
      end
    endcase

    if (restart_req) begin
      n.st = acn_pkg::ST_NEG_ENABLE;
    end
    if (!n.ctrl[acn_pkg::CTRL_SENSE_BIT]) begin
      n.fault = acn_pkg::RF_OK;
    end
    if (n.st != r.st) begin
      n.tmr = '0;
    end
    flush_c = (n.st != r.st) &&
              (n.st == acn_pkg::ST_ABILITY || n.st == acn_pkg::ST_NEG_ENABLE);

    unique case (n.st)
      acn_pkg::ST_LINK_OK, acn_pkg::ST_DISABLED: n.xmit = acn_pkg::XMIT_DATA;
      acn_pkg::ST_IDLE_DETECT:                   n.xmit = acn_pkg::XMIT_IDLE;
      default:                                   n.xmit = acn_pkg::XMIT_CFG;
    endcase
    n.done = (n.st == acn_pkg::ST_LINK_OK);

    // next sent word, built from the next page mode so no stale word slips out
    page_n = mk_page(n.np_mode, n.nptx, adv_eff, fault_g);
    if (n.st == acn_pkg::ST_RESTART || n.st == acn_pkg::ST_NEG_ENABLE) begin
      n.tx_word = 16'h0000;
    end else if (n.st == acn_pkg::ST_COMPLETE_ACK && r.st == acn_pkg::ST_COMPLETE_ACK) begin
      n.tx_word = r.tx_word;
    end else if (n.st == acn_pkg::ST_ACK || n.st == acn_pkg::ST_COMPLETE_ACK ||
                 n.st == acn_pkg::ST_NP_WAIT) begin
      n.tx_word = page_n | acn_pkg::ACK_M;
    end else begin
      n.tx_word = page_n;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r      <= '0;
      r.st   <= acn_pkg::ST_NEG_ENABLE;
      r.ctrl <= acn_pkg::CTRL_RST;
      r.adv  <= acn_pkg::ADV_RST;
    end else begin
      r <= n;
    end
  end

  // zero wait states and OKAY only, so these stay constant
  assign hreadyout_o       = 1'b1;
  assign hresp_o           = 1'b0;
  assign hrdata_o          = r.rdata;
  assign xmit_o            = r.xmit;
  assign tx_cfg_word_o     = r.tx_word;
  assign an_done_o         = r.done;
  assign res_full_duplex_o = r.fd;
  assign res_pause_tx_o    = r.ptx;
  assign res_pause_rx_o    = r.prx;

  a_restart_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    r.st == acn_pkg::ST_RESTART |-> tx_cfg_word_o == 16'h0000 && xmit_o == acn_pkg::XMIT_CFG)
    else $error("restart must send zero words as config sets");
  a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !r.np_mode |-> (tx_cfg_word_o & 16'h0e1f) == 16'h0000)
    else $error("reserved base page bit sent as one");
  a_ack_after_match: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(tx_cfg_word_o[acn_pkg::ACK_BIT]) |-> $past(mi.ability_match))
    else $error("confirm flag raised without a repeat match");
  a_fault_sync_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !$past(sync_ok_i) && !r.np_mode |-> tx_cfg_word_o[13:12] == acn_pkg::RF_OK)
    else $error("fault code sent while sync failed");
  a_complete_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    r.st == acn_pkg::ST_COMPLETE_ACK && $past(r.st) == acn_pkg::ST_COMPLETE_ACK
    |-> $stable(tx_cfg_word_o) && xmit_o == acn_pkg::XMIT_CFG)
    else $error("word changed during complete-confirm hold");
  a_idle_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(r.st) == acn_pkg::ST_COMPLETE_ACK && r.st == acn_pkg::ST_IDLE_DETECT &&
    !r.np_mode |-> r.fault == acn_pkg::RF_OK && xmit_o == acn_pkg::XMIT_IDLE)
    else $error("fault code not cleared at idle watch");
  a_fd_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(r.st) == acn_pkg::ST_COMPLETE_ACK && r.st == acn_pkg::ST_IDLE_DETECT
    |-> r.fd == ($past(adv_eff[acn_pkg::FD_BIT]) && $past(r.lpw[acn_pkg::FD_BIT])))
    else $error("full duplex resolution wrong");
  a_rflt_sticky: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rflt_set |=> r.rflt)
    else $error("partner fault status not set");
  a_zero_linkfail: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    r.st == acn_pkg::ST_ABILITY && zero_to && r.ctrl[acn_pkg::CTRL_SENSE_BIT] &&
    !mi.ability_match && !restart_req
    |=> r.fault == acn_pkg::RF_LINKFAIL && r.st == acn_pkg::ST_NEG_ENABLE)
    else $error("zero word timeout not flagged as link failure");
  a_no_sense_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !r.ctrl[acn_pkg::CTRL_SENSE_BIT] |-> r.fault == acn_pkg::RF_OK)
    else $error("fault code held with sensing off");
endmodule : acn_top

// ==== acn_partner.sv ====
// Purpose: link partner that sends its page and confirms after three equal words
// Assumes: local sends config sets while xmit is config
// Notes:   word line alternates between the inverted and the last value between sets
`timescale 1ns/1ps
module acn_partner (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // local transmit side and scenario control
  input  wire logic [1:0]  xmit_i,
  input  wire logic [15:0] tx_word_i,
  input  wire logic [15:0] page_i,
  input  wire logic [3:0]  gap_i,
  // toward local receive path
  output logic             cfg_valid_o,
  output logic      [15:0] cfg_word_o,
  output logic             idle_o
);
  logic [3:0]  cnt_r;
  logic [1:0]  seen_r;
  logic [15:0] last_r;
  logic        send;
  assign send = (cnt_r == 4'h0) && (xmit_i == acn_pkg::XMIT_CFG);
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r       <= 4'h0;
      seen_r      <= 2'h0;
      last_r      <= 16'h0;
      cfg_valid_o <= 1'b0;
      idle_o      <= 1'b0;
      cfg_word_o  <= 16'hffff;
    end else begin
      cnt_r       <= (cnt_r >= gap_i) ? 4'h0 : cnt_r + 4'h1;
      cfg_valid_o <= send;
      idle_o      <= (cnt_r == 4'h0) && !send;
      cfg_word_o  <= ~cfg_word_o;
      if (send) begin
        last_r     <= tx_word_i & ~acn_pkg::ACK_M;
        // zeros from the local end mean restart, so history is dropped
        seen_r     <= (tx_word_i == 16'h0) ? 2'h0 :
                      ((tx_word_i & ~acn_pkg::ACK_M) != last_r) ? 2'h1 :
                      (seen_r == 2'h3) ? 2'h3 : seen_r + 2'h1;
        // an empty page keeps the partner in restart, so it never confirms
        cfg_word_o <= (tx_word_i == 16'h0 || page_i == 16'h0) ? 16'h0 :
                      page_i | {1'b0, seen_r == 2'h3, 14'h0};
      end
    end
  end
endmodule : acn_partner

// ==== acn_top_test.sv ====
// Purpose: self-checking bench for the configuration word exchange
// Assumes: link timer shortened to 20 cycles
// Notes:   expectations queue up, a monitor compares them
`timescale 1ns/1ps
module acn_top_test;
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, xmit;
  logic        hwrite = 1'b0, rdy, resp, done, fd, ptx, prx, pv, pi;
  logic        sync_ok = 1'b1, rd_take = 1'b0, ln_take = 1'b0;
  logic [15:0] txw, pw, page = 16'h01a0;
  logic [3:0]  gap = 4'h1;
  logic [7:0]  lfsr = 8'h1c;
  logic [31:0] rd_q[$];
  logic [21:0] ln_q[$], lnv, ln_m = 22'h0;
  int          failures = 0, checked = 0;
  // line state: resolution, done, selector, sent word
  assign lnv = {fd, ptx, prx, done, xmit, txw};
  always #12.5 clk_sys_i = ~clk_sys_i;
  acn_top #(.LINK_TIMER_CYC(20)) i_acn_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp),
    .rx_cfg_valid_i(pv), .rx_cfg_word_i(pw), .rx_idle_i(pi), .rx_invalid_i(1'b0),
    .sync_ok_i(sync_ok), .xmit_o(xmit), .tx_cfg_word_o(txw), .an_done_o(done),
    .res_full_duplex_o(fd), .res_pause_tx_o(ptx), .res_pause_rx_o(prx));
  acn_partner i_acn_partner (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .xmit_i(xmit),
    .tx_word_i(txw), .page_i(page), .gap_i(gap), .cfg_valid_o(pv), .cfg_word_o(pw),
    .idle_o(pi));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic results();
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH register read exp %h got %h", e, g);
    end
  endtask : cmp_rd
  task automatic cmp_ln(input logic [21:0] e, input logic [21:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH line state exp %h got %h", e, g);
    end
  endtask : cmp_ln
  always @(posedge clk_sys_i) begin
    if (rd_take) cmp_rd({1'b0, rd_q.pop_front()}, {resp, hrdata});
    if (ln_take) cmp_ln(ln_q.pop_front(), lnv & ln_m);
  end
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      failures++;
      $display("MISMATCH bus ready exp 1 got %b", rdy);
      results();
    end
  endtask : bus_wait
  // for reads d is the expected data
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    bus_wait();
    htrans  <= 2'h0;
    hwdata  <= d;
    rd_take <= ~wr;
    if (!wr) rd_q.push_back(d);
    bus_wait();
    rd_take <= 1'b0;
  endtask : bus
  task automatic line(input logic [21:0] m, input logic [21:0] e, input int lim);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while ((lnv & m) !== (e & m) && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
    if ((lnv & m) !== (e & m)) begin
      failures++;
      $display("MISMATCH line wait exp %h got %h", e, lnv);
      results();
    end
    // the monitor takes the state seen here at the next rising edge
    ln_m = m;
    ln_q.push_back(e & m);
    ln_take <= 1'b1;
    @(posedge clk_sys_i);
    ln_take <= 1'b0;
  endtask : line
  task automatic reroll();
    gap  <= {2'h0, lfsr[1:0]} + 4'h1;
    lfsr = lfsr_next(lfsr);
  endtask : reroll
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    line(22'h3fffff, 22'h000000, 4);
    bus(acn_pkg::REG_CTRL, 1'b0, 32'h5);
    bus(acn_pkg::REG_ADV, 1'b0, 32'h1a0);
    bus(acn_pkg::REG_FAULT, 1'b0, 32'h0);
    bus(8'h18, 1'b0, 32'h0);
    reroll();
    line(22'h00ffff, 22'h0001a0, 200);
    line(22'h00ffff, 22'h0041a0, 200);
    line(22'h3f0000, 22'h3e0000, 400);
    bus(acn_pkg::REG_STAT, 1'b0, 32'h3d);
    page <= 16'h21a0;
    reroll();
    bus(acn_pkg::REG_FAULT, 1'b1, 32'h1);
    line(22'h00ffff, 22'h0011a0, 8);
    sync_ok <= 1'b0;
    line(22'h00ffff, 22'h0001a0, 8);
    sync_ok <= 1'b1;
    bus(acn_pkg::REG_CTRL, 1'b1, 32'h7);
    line(22'h00ffff, 22'h0011a0, 200);
    line(22'h3f0000, 22'h3e0000, 400);
    bus(acn_pkg::REG_FAULT, 1'b0, 32'h0);
    bus(acn_pkg::REG_STAT, 1'b0, 32'h3f);
    bus(acn_pkg::REG_STAT, 1'b1, 32'h2);
    bus(acn_pkg::REG_STAT, 1'b0, 32'h3d);
    bus(acn_pkg::REG_CTRL, 1'b1, 32'h3);
    bus(acn_pkg::REG_FAULT, 1'b1, 32'h3);
    bus(acn_pkg::REG_FAULT, 1'b0, 32'h0);
    line(22'h00ffff, 22'h0001a0, 200);
    page <= 16'h0000;
    reroll();
    bus(acn_pkg::REG_CTRL, 1'b1, 32'h7);
    line(22'h00ffff, 22'h0021a0, 400);
    page <= 16'h0180;
    reroll();
    bus(acn_pkg::REG_FAULT, 1'b1, 32'h0);
    bus(acn_pkg::REG_CTRL, 1'b1, 32'h7);
    line(22'h00ffff, 22'h0031a0, 600);
    results();
  end
endmodule : acn_top_test
